//--- oprp_pkg.sv
// constants and carrier types of the off-line switcher sequencing block
package oprp_pkg;

  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int OSC_FREQ_HZ = 100_000;
  localparam logic [7:0] OSC_PERIOD_CYC = 8'(CLK_FREQ_HZ / OSC_FREQ_HZ);
  localparam logic [7:0] MAX_ON_TICKS = 8'h8C;
  localparam logic [7:0] MIN_ON_TICKS = 8'h0A;
  localparam logic [7:0] BLANK_TICKS = 8'h04;
  localparam logic [2:0] RESTART_LAST = 3'h7; // eighth cycle ends restart
  // analog thresholds, kept for reference only (millivolts, deg C)
  localparam int VC_LOW_MV = 4700;
  localparam int VC_HIGH_MV = 5700;
  localparam int TSD_DEG_C = 145;

  // ********************************************************************
  // register map
  // ********************************************************************
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_FBMIN = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_FBCODE = 4'hC;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [7:0] FBMIN_RST = 8'h20;

  // ********************************************************************
  // types
  // ********************************************************************
  typedef enum logic [1:0] {
    ST_CHARGE = 2'h0,
    ST_RUN = 2'h1,
    ST_RESTART = 2'h3,
    ST_LATCHED = 2'h2
  } oprp_state_t;

  typedef struct packed {
    logic supplyHigh;
    logic supplyLow;
    logic curLimit;
    logic ovPulse;
    logic overTemp;
    logic fbPresent;
  } oprp_cmp_t;

endpackage

//--- oprp_supply_model.sv
// supply capacitor and feedback model seen by the switcher block
module oprp_supply_model #(
  parameter int LVL_HI = 16,
  parameter int LVL_LO = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // device controls and bench command
  input wire logic chargeOn,
  input wire logic fbOk,
  // comparator decisions
  output logic supplyHigh,
  output logic supplyLow,
  output logic fbPresent
);
  timeunit 1ns;
  timeprecision 1ns;
  int lvl;
  // charge ramps up; without feedback current the capacitor drains
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      lvl <= 0; // power removal empties the capacitor
    else if (chargeOn)
      lvl <= (lvl < 20) ? lvl + 1 : lvl;
    else if (!fbOk)
      lvl <= (lvl > 0) ? lvl - 1 : lvl;
  end
  // thresholds held apart so both never show at once
  assign supplyHigh = (lvl >= LVL_HI);
  assign supplyLow = (lvl <= LVL_LO);
  assign fbPresent = fbOk; // regulation loss interrupts feedback
endmodule

//--- oprp_top.sv
// sequencing, modulator and protection logic with an AHB-Lite register slave
//
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
module oprp_top #(
  parameter logic [7:0] PERIOD = oprp_pkg::OSC_PERIOD_CYC,
  parameter logic [7:0] MAX_ON = oprp_pkg::MAX_ON_TICKS,
  parameter logic [7:0] MIN_ON = oprp_pkg::MIN_ON_TICKS,
  parameter logic [7:0] BLANK = oprp_pkg::BLANK_TICKS
) (
  // clock and power-up reset
  input wire logic clk_sys,
  input wire logic rst,
  // comparator decisions and feedback current code
  input oprp_pkg::oprp_cmp_t cmpIn,
  input wire logic [7:0] fbCode,
  // power stage controls
  output logic switchOn,
  output logic chargeOn,
  output logic shuntMode,
  output logic standby,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  // ********************************************************************
  // comparator synchroniser
  // ********************************************************************
  oprp_pkg::oprp_cmp_t syncA_reg;
  oprp_pkg::oprp_cmp_t cmp_reg;
  logic supHighD_reg;
  logic hiRise;

  // two flops per decision; only cmp_reg is looked at
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      syncA_reg <= '0;
      cmp_reg <= '0;
      supHighD_reg <= 1'b0;
    end
    else
    begin
      syncA_reg <= cmpIn;
      cmp_reg <= syncA_reg;
      supHighD_reg <= cmp_reg.supplyHigh;
    end
  end

  assign hiRise = cmp_reg.supplyHigh & ~supHighD_reg;

  // ********************************************************************
  // register file
  // ********************************************************************
  logic ctrlEn_reg;
  logic [7:0] fbMin_reg;
  logic [7:0] fbCode_reg;
  logic wrPend_reg;
  logic [3:0] wrAddr_reg;
  logic addrPhase;
  logic [31:0] rdData_next;
  oprp_pkg::oprp_state_t state_reg;
  logic ovLatch_reg;
  logic otLatch_reg;
  logic [2:0] restartCnt_reg;

  assign addrPhase = hsel & htrans[1] & hready;

  // feedback code is a synchronous bus, captured once for a stable compare
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      fbCode_reg <= 8'h00;
    else
      fbCode_reg <= fbCode;
  end

  // write data arrives in the data phase, so the address is held one cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 4'h0;
    end
    else
    begin
      // only the mapped window takes writes, so 0x10 and up never alias
      wrPend_reg <= addrPhase & hwrite & (haddr[31:4] == 28'h0000000);
      wrAddr_reg <= haddr[3:0];
    end
  end

  // software-steered controls
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrlEn_reg <= oprp_pkg::CTRL_EN_RST;
      fbMin_reg <= oprp_pkg::FBMIN_RST;
    end
    else if (wrPend_reg)
    begin
      if (wrAddr_reg == oprp_pkg::OFS_CTRL)
        ctrlEn_reg <= hwdata[oprp_pkg::CTRL_EN_BIT];
      if (wrAddr_reg == oprp_pkg::OFS_FBMIN)
        fbMin_reg <= hwdata[7:0];
    end
  end

  // read mux; unmapped words read as zero
  always_comb
  begin
    rdData_next = 32'h0000_0000;
    if (haddr[31:4] == 28'h0000000)
    begin
      unique case (haddr[3:0])
        oprp_pkg::OFS_CTRL: rdData_next[0] = ctrlEn_reg;
        oprp_pkg::OFS_FBMIN: rdData_next[7:0] = fbMin_reg;
        oprp_pkg::OFS_STATUS: rdData_next[10:0] = {1'b0, shuntMode,
            restartCnt_reg, otLatch_reg, ovLatch_reg, chargeOn, switchOn,
            state_reg};
        oprp_pkg::OFS_FBCODE: rdData_next[7:0] = fbCode_reg;
        default: rdData_next = 32'h0000_0000;
      endcase
    end
  end

  // zero wait states: read data is latched at the address edge
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addrPhase & ~hwrite)
        hrdata <= rdData_next;
    end
  end

  // ********************************************************************
  // shutdown latches
  // ********************************************************************
  logic fault;

  // only the power-up reset clears these
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ovLatch_reg <= 1'b0;
      otLatch_reg <= 1'b0;
    end
    else
    begin
      if (cmp_reg.ovPulse)
        ovLatch_reg <= 1'b1;
      if (cmp_reg.overTemp)
        otLatch_reg <= 1'b1;
    end
  end

  assign fault = ovLatch_reg | otLatch_reg;

  // ********************************************************************
  // supply sequencing
  // ********************************************************************
  // start-up, normal run, auto-restart and latched off
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      state_reg <= oprp_pkg::ST_CHARGE;
    else if (fault)
      state_reg <= oprp_pkg::ST_LATCHED;
    else
    begin
      unique case (state_reg)
        oprp_pkg::ST_CHARGE:
          if (cmp_reg.supplyHigh)
            state_reg <= oprp_pkg::ST_RUN;
        oprp_pkg::ST_RUN:
          if (cmp_reg.supplyLow)
            state_reg <= oprp_pkg::ST_RESTART;
        oprp_pkg::ST_RESTART:
          if (hiRise && restartCnt_reg == oprp_pkg::RESTART_LAST)
            state_reg <= oprp_pkg::ST_RUN;
        oprp_pkg::ST_LATCHED:
          state_reg <= oprp_pkg::ST_LATCHED;
      endcase
    end
  end

  // counts completed charge phases while restarting
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      restartCnt_reg <= 3'h0;
    else if (state_reg != oprp_pkg::ST_RESTART)
      restartCnt_reg <= 3'h0;
    else if (hiRise)
      restartCnt_reg <= restartCnt_reg + 3'h1;
  end

  // high-voltage source: off while switching, hysteretic otherwise
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      chargeOn <= 1'b1;
    else if (state_reg == oprp_pkg::ST_RUN && !fault)
      chargeOn <= cmp_reg.supplyLow;
    else if (cmp_reg.supplyLow)
      chargeOn <= 1'b1;
    else if (cmp_reg.supplyHigh)
      chargeOn <= 1'b0;
  end

  // shunt regulation only while running with feedback current present
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      shuntMode <= 1'b0;
      standby <= 1'b1;
    end
    else
    begin
      shuntMode <= (state_reg == oprp_pkg::ST_RUN) & cmp_reg.fbPresent
          & ~fault;
      standby <= state_reg != oprp_pkg::ST_RUN;
    end
  end

  // ********************************************************************
  // oscillator and modulator
  // ********************************************************************
  logic [7:0] phase_reg;
  logic oscStart;
  logic runOk;
  logic [7:0] fbExcess;
  logic [7:0] onLimit;
  logic offNow;

  // sawtooth position within the switching period
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      phase_reg <= 8'h00;
    else if (phase_reg == PERIOD - 8'h01)
      phase_reg <= 8'h00;
    else
      phase_reg <= phase_reg + 8'h01;
  end

  assign oscStart = phase_reg == 8'h00;
  assign runOk = (state_reg == oprp_pkg::ST_RUN) & ~fault & ctrlEn_reg
      & ~cmp_reg.supplyLow;

  // error level: maximum duty (MAX_ON) until feedback passes the minimum
  always_comb
  begin
    fbExcess = 8'h00;
    onLimit = MAX_ON;
    if (fbCode_reg > fbMin_reg)
    begin
      fbExcess = fbCode_reg - fbMin_reg;
      onLimit = (fbExcess >= MAX_ON) ? 8'h00 : MAX_ON - fbExcess;
    end
  end

  // the error path may not end a pulse inside the minimum on-time;
  // current limit after blanking can, since it protects the switch
  assign offNow = (phase_reg >= MAX_ON)
      | (phase_reg >= MIN_ON && phase_reg >= onLimit)
      | (phase_reg >= BLANK && cmp_reg.curLimit);

  // on-latch: set by the oscillator, reset by modulator or limit
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      switchOn <= 1'b0;
    else if (!runOk)
      switchOn <= 1'b0;
    else if (oscStart)
      switchOn <= 1'b1;
    else if (offNow)
      switchOn <= 1'b0;
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  property p_startup;
    @(posedge clk_sys) disable iff (rst)
    (state_reg == oprp_pkg::ST_CHARGE && cmp_reg.supplyHigh && !fault)
    |=> (state_reg == oprp_pkg::ST_RUN) && !chargeOn;
  endproperty
  a_startup: assert property (p_startup)
    else $error("start-up did not hand over to switching");

  property p_lowexit;
    @(posedge clk_sys) disable iff (rst)
    (state_reg == oprp_pkg::ST_RUN && cmp_reg.supplyLow && !fault)
    |=> (state_reg == oprp_pkg::ST_RESTART) && chargeOn && !switchOn;
  endproperty
  a_lowexit: assert property (p_lowexit)
    else $error("low supply did not stop switching");

  property p_hyst;
    @(posedge clk_sys) disable iff (rst)
    (state_reg != oprp_pkg::ST_RUN && cmp_reg.supplyLow)
    |=> chargeOn;
  endproperty
  a_hyst: assert property (p_hyst)
    else $error("charging source not on at lower threshold");

  property p_restart;
    @(posedge clk_sys) disable iff (rst)
    (state_reg == oprp_pkg::ST_RESTART && !fault && hiRise
        && restartCnt_reg == 3'h7)
    |=> (state_reg == oprp_pkg::ST_RUN) ##1 (restartCnt_reg == 3'h0);
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not end after eight cycles");

  property p_noswitch;
    @(posedge clk_sys) disable iff (rst)
    (state_reg != oprp_pkg::ST_RUN) |=> !switchOn;
  endproperty
  a_noswitch: assert property (p_noswitch)
    else $error("switch on outside normal switching");

  property p_oscset;
    @(posedge clk_sys) disable iff (rst)
    (runOk && phase_reg == 8'h00)
    |=> switchOn ##1 (switchOn || !$past(runOk));
  endproperty
  a_oscset: assert property (p_oscset)
    else $error("oscillator did not start a pulse");

  property p_maxduty;
    @(posedge clk_sys) disable iff (rst)
    (phase_reg > MAX_ON) |-> !switchOn;
  endproperty
  a_maxduty: assert property (p_maxduty)
    else $error("pulse ran past maximum duty");

  property p_minon;
    @(posedge clk_sys) disable iff (rst)
    (switchOn && runOk && phase_reg < MIN_ON
        && !(cmp_reg.curLimit && phase_reg >= BLANK))
    |=> switchOn;
  endproperty
  a_minon: assert property (p_minon)
    else $error("pulse ended before minimum on-time");

  property p_curlim;
    @(posedge clk_sys) disable iff (rst)
    (switchOn && cmp_reg.curLimit && phase_reg >= BLANK)
    |=> !switchOn;
  endproperty
  a_curlim: assert property (p_curlim)
    else $error("current limit did not end the pulse");

  property p_stayoff;
    @(posedge clk_sys) disable iff (rst)
    (!switchOn && phase_reg != 8'h00) |=> !switchOn;
  endproperty
  a_stayoff: assert property (p_stayoff)
    else $error("switch restarted inside a period");

  property p_ovp;
    @(posedge clk_sys) disable iff (rst)
    cmp_reg.ovPulse |=> ovLatch_reg ##1 (!switchOn && ovLatch_reg);
  endproperty
  a_ovp: assert property (p_ovp)
    else $error("overvoltage latch did not shut the switch");

  property p_otp;
    @(posedge clk_sys) disable iff (rst)
    otLatch_reg |=> otLatch_reg && !switchOn
        && (state_reg == oprp_pkg::ST_LATCHED);
  endproperty
  a_otp: assert property (p_otp)
    else $error("thermal latch released or switch on");

  c_start: cover property (@(posedge clk_sys) disable iff (rst)
    state_reg == oprp_pkg::ST_CHARGE ##1 state_reg == oprp_pkg::ST_RUN);
  c_back: cover property (@(posedge clk_sys) disable iff (rst)
    state_reg == oprp_pkg::ST_RESTART ##1 state_reg == oprp_pkg::ST_RUN);
  c_limit: cover property (@(posedge clk_sys) disable iff (rst)
    switchOn && cmp_reg.curLimit && phase_reg >= BLANK);
  c_latch: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(state_reg == oprp_pkg::ST_LATCHED));

endmodule

//--- tb_top.sv
// self-checking bench of the switcher sequencing block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // short period keeps pulse measurements and quiet windows brief
  localparam logic [7:0] P_PER = 8'h28;
  localparam logic [7:0] P_MAX = 8'h1C;
  localparam logic [7:0] P_MIN = 8'h0A;
  localparam logic [7:0] P_BLK = 8'h04;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic curLim = 1'b0;
  logic ovP = 1'b0;
  logic hot = 1'b0;
  logic fbOk = 1'b1;
  logic sHigh, sLow, fbPres, prevH, prevC;
  oprp_pkg::oprp_cmp_t cmpIn;
  logic [7:0] fbCode = 8'h00;
  logic [7:0] fb;
  logic switchOn, chargeOn, shuntMode, standby, hreadyout, hresp;
  logic [31:0] hrdata, q;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  int error_cnt = 0;
  int checks = 0;
  int w, per, h, g, r;

  // ****************
  // plumbing
  // ****************
  assign cmpIn = {sHigh, sLow, curLim, ovP, hot, fbPres};
  initial
  begin
    forever #25 clk_sys = ~clk_sys;
  end
  oprp_supply_model i_supply (.clk_sys(clk_sys), .rst(rst),
    .chargeOn(chargeOn), .fbOk(fbOk), .supplyHigh(sHigh),
    .supplyLow(sLow), .fbPresent(fbPres));
  oprp_top #(.PERIOD(P_PER), .MAX_ON(P_MAX), .MIN_ON(P_MIN),
    .BLANK(P_BLK)) i_dut (.clk_sys(clk_sys), .rst(rst), .cmpIn(cmpIn),
    .fbCode(fbCode), .switchOn(switchOn), .chargeOn(chargeOn),
    .shuntMode(shuntMode), .standby(standby), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata));

  // ****************
  // helpers
  // ****************
  task automatic final_report;
    if (error_cnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic timeout;
    error_cnt++;
    $display("wrong value at %0t: wait timed out", $time);
    final_report();
  endtask
  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: bit %b not %b", $time, got, exp);
    end
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  // master holds each phase until hready is sampled high
  task automatic ready_wait;
    int k;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 20);
    if (k >= 20)
      timeout();
  endtask
  task automatic bus(input logic [31:0] a, input logic wr,
    input logic [31:0] d, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    ready_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    ready_wait();
    rd = hrdata;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return switchOn;
      1: return chargeOn;
      2: return shuntMode;
      default: return standby;
    endcase
  endfunction
  task automatic wait_for(input int s, input logic v);
    int k;
    k = 0;
    while (sig(s) !== v && k < 900)
    begin
      @(negedge clk_sys);
      k++;
    end
    if (k >= 900)
      timeout();
  endtask
  // width of one whole pulse and rise-to-rise spacing, in cycles
  task automatic measure(output int wd, output int pd);
    wait_for(0, 1'b0);
    wait_for(0, 1'b1);
    wd = 0;
    while (switchOn === 1'b1 && wd < 300)
    begin
      @(negedge clk_sys);
      wd++;
    end
    pd = wd;
    while (switchOn === 1'b0 && pd < 300)
    begin
      @(negedge clk_sys);
      pd++;
    end
  endtask
  // counts switch-on cycles and charge-source turn-ons
  task automatic quiet(input int c, output int hs, output int gs);
    hs = 0;
    gs = 0;
    repeat (c)
    begin
      @(negedge clk_sys);
      if (switchOn !== 1'b0)
        hs++;
      if (chargeOn === 1'b1 && prevC === 1'b0)
        gs++;
      prevC = chargeOn;
    end
  endtask
  // pulse length the error path asks for, clamped by min and max
  function automatic int exp_width(input logic [7:0] f, input logic [7:0] m);
    int lim;
    lim = (f <= m) ? int'(P_MAX) : int'(P_MAX) - int'(f - m);
    if (lim < int'(P_MIN))
      lim = int'(P_MIN);
    return lim;
  endfunction
  task automatic do_reset;
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk1(switchOn, 1'b0);
    chk1(chargeOn & standby & hreadyout & ~hresp & ~shuntMode, 1'b1);
    bus(32'h8, 1'b0, 32'h0, q);
    chk32(q, 32'h8);
    wait_for(1, 1'b0);
    // standby follows the state one cycle later
    @(negedge clk_sys);
    chk1(sHigh & ~standby, 1'b1);
    bus(32'h8, 1'b0, 32'h0, q);
    chk32(q & 32'hB, 32'h1);
  endtask

  // ****************
  // scenarios
  // ****************
  initial
  begin
    void'($urandom(72596));
    do_reset();
    bus(32'h0, 1'b0, 32'h0, q);
    chk32(q, 32'h1);
    bus(32'h4, 1'b0, 32'h0, q);
    chk32(q, 32'h20);
    bus(32'h10, 1'b0, 32'h0, q);
    chk32(q, 32'h0);
    // corners first, then random error levels
    for (int i = 0; i < 10; i++)
    begin
      fb = (i == 0) ? 8'h20 : (i == 1) ? 8'hFF : 8'($urandom_range(95, 0));
      @(posedge clk_sys);
      fbCode <= fb;
      measure(w, per);
      measure(w, per);
      chk32(w, exp_width(fb, 8'h20));
      chk32(per, 32'(P_PER));
      bus(32'hC, 1'b0, 32'h0, q);
      chk32(q, 32'(fb));
    end
    bus(32'h4, 1'b1, 32'h10, q);
    measure(w, per);
    measure(w, per);
    chk32(w, exp_width(fb, 8'h10));
    bus(32'h4, 1'b1, 32'h20, q);
    bus(32'h0, 1'b1, 32'h0, q);
    // the enable lands at the write edge; the switch drops one edge later
    @(posedge clk_sys);
    quiet(2 * P_PER, h, g);
    chk32(h + g, 0);
    bus(32'h0, 1'b1, 32'h1, q);
    // current limit held high: pulse ends once blanking is over
    @(posedge clk_sys);
    fbCode <= 8'h00;
    curLim <= 1'b1;
    measure(w, per);
    measure(w, per);
    chk32(w, 32'(P_BLK));
    chk32(per, 32'(P_PER));
    @(posedge clk_sys);
    curLim <= 1'b0;
    // regulation lost: auto-restart, then regained
    fbOk <= 1'b0;
    wait_for(2, 1'b0);
    wait_for(3, 1'b1);
    chk1(~switchOn & chargeOn, 1'b1);
    bus(32'h8, 1'b0, 32'h0, q);
    chk32(q & 32'hF, 32'hB);
    r = 0;
    h = 0;
    g = 0;
    w = 0;
    prevH = sHigh;
    prevC = chargeOn;
    while (r < 8 && w < 3000)
    begin
      @(negedge clk_sys);
      w++;
      if (sHigh && !prevH)
        r++;
      if (chargeOn === 1'b1 && prevC === 1'b0)
        g++;
      if (switchOn !== 1'b0)
        h++;
      prevH = sHigh;
      prevC = chargeOn;
    end
    chk32(r, 8);
    chk32(h, 0);
    chk32(g, 7);
    @(posedge clk_sys);
    fbOk <= 1'b1;
    wait_for(0, 1'b1);
    bus(32'h8, 1'b0, 32'h0, q);
    chk32(q & 32'h3CB, 32'h201);
    // overvoltage pulse, then over-temperature
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk_sys);
      ovP <= (i == 0);
      hot <= (i == 1);
      fbOk <= 1'b0;
      repeat (2) @(posedge clk_sys);
      ovP <= 1'b0;
      hot <= 1'b0;
      quiet(8, h, g);
      quiet(3 * P_PER, h, g);
      chk32(h, 0);
      chk1(g > 0, 1'b1);
      bus(32'h8, 1'b0, 32'h0, q);
      chk32(q & 32'h37, (i == 0) ? 32'h12 : 32'h22);
      @(posedge clk_sys);
      fbOk <= 1'b1;
      quiet(3 * P_PER, h, g);
      chk32(h, 0);
      do_reset();
    end
    final_report();
  end
endmodule
